// [shared/page0_regs_pkg.sv]
`default_nettype none
package page0_regs_pkg;
  // register index; byte address is four times the index
  localparam logic [5:0] IDX_PAGE = 6'h00;
  localparam logic [5:0] IDX_CMD = 6'h01;
  localparam logic [5:0] IDX_IEN = 6'h02;
  localparam logic [5:0] IDX_FLAGS = 6'h10;
  localparam logic [5:0] IDX_DRIVE = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;
  localparam logic [5:0] IDX_FORCE = 6'h13;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h20;
  localparam logic [7:0] IEN_RST = 8'h80;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam int PAGE_OVR_BIT = 7;
  localparam int RX_OFF_BIT = 5;
  localparam int SLEEP_BIT = 4;
  localparam int INV_BIT = 7;
  localparam int DRIVE_BIT = 7;
  localparam int WAKING_BIT = 5;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam int IDLE_FLAG_BIT = 4;
  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_ASLEEP = 2'b01,
    PWR_WAKING = 2'b11
  } pwr_state_t;
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic high_level;
    logic low_level;
    logic fault;
    logic countdown;
  } req_events_t;
  typedef struct packed {
    logic start;
    logic [3:0] code;
  } cmd_launch_t;
endpackage
`default_nettype wire

// [hw/page0_control_regs.sv]
// Decided for this implementation: the APB register port.
`default_nettype none
module page0_control_regs #(
  parameter int ADDR_W = 8,
  parameter logic [3:0] SOFT_REINIT_CODE = 4'hF,
  parameter logic [15:0] KNOWN_CMD_MASK = 16'h80FF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] addr_latch,
  output logic [5:0] reg_addr,
  input wire page0_regs_pkg::req_events_t events,
  input wire logic cmd_done,
  input wire logic wake_ready,
  output page0_regs_pkg::cmd_launch_t launch,
  output logic receiver_analog_off,
  output logic soft_sleep_req,
  output logic irq,
  output logic irq_pin_out,
  output logic irq_pin_oe
);
  // the map needs eight address bits; narrower buses cannot reach it
  if (ADDR_W < 8)
  begin : g_addr_w_check
    $error("ADDR_W too small for register map");
  end

  logic [7:0] page_q;
  logic [7:0] ien_q;
  logic [7:0] drive_q;
  logic rx_off_q;
  logic [3:0] cmd_q;
  logic [6:0] flags_q;
  logic [6:0] flags_d;
  page0_regs_pkg::pwr_state_t pwr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [5:0] reg_addr_q;
  page0_regs_pkg::cmd_launch_t launch_q;
  logic irq_q;
  logic pin_out_q;
  logic pin_oe_q;

  logic [5:0] idx;
  logic wr;
  logic mapped;
  logic [7:0] wbyte;
  logic wr_cmd;
  logic cmd_known;
  logic reinit_active;
  logic self_idle;
  logic unknown_idle;
  logic combined;
  logic pin_level;

  assign idx = paddr[7:2];
  assign wbyte = pwdata[7:0];
  // shift instead of a part-select so the default width has no empty range
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr >> 8) == '0) &&
    (idx == page0_regs_pkg::IDX_PAGE || idx == page0_regs_pkg::IDX_CMD ||
     idx == page0_regs_pkg::IDX_IEN || idx == page0_regs_pkg::IDX_FLAGS ||
     idx == page0_regs_pkg::IDX_DRIVE || idx == page0_regs_pkg::IDX_STATUS ||
     idx == page0_regs_pkg::IDX_FORCE);
  // writes land only at the access edge
  assign wr = psel && penable && pready_q && pwrite && mapped;
  assign wr_cmd = wr && (idx == page0_regs_pkg::IDX_CMD);
  assign cmd_known = KNOWN_CMD_MASK[wbyte[3:0]];
  assign reinit_active = (cmd_q == SOFT_REINIT_CODE);
  assign self_idle = cmd_done && (cmd_q != page0_regs_pkg::CMD_IDLE);
  assign unknown_idle = wr_cmd && !cmd_known;

  // apb: no wait state; read data is registered in the setup phase so it comes from a flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pready_q <= 1'b0;
    else
      pready_q <= psel && !penable && !pready_q;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pslverr_q <= 1'b0;
    else
      pslverr_q <= psel && !penable && !mapped;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (idx)
        page0_regs_pkg::IDX_PAGE: prdata_q <= {24'h000000, page_q};
        page0_regs_pkg::IDX_CMD: prdata_q <= {24'h000000, 2'b00, rx_off_q,
          (pwr_q != page0_regs_pkg::PWR_AWAKE), cmd_q};
        page0_regs_pkg::IDX_IEN: prdata_q <= {24'h000000, ien_q};
        page0_regs_pkg::IDX_FLAGS: prdata_q <= {25'h0000000, flags_q};
        page0_regs_pkg::IDX_DRIVE: prdata_q <= {24'h000000, drive_q};
        page0_regs_pkg::IDX_STATUS: prdata_q <= {26'h0000000,
          (pwr_q == page0_regs_pkg::PWR_WAKING), combined, cmd_q};
        page0_regs_pkg::IDX_FORCE: prdata_q <= 32'h0000_0000;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // control-only bits: nothing but the host writes them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      page_q <= page0_regs_pkg::PAGE_RST;
    else if (wr && idx == page0_regs_pkg::IDX_PAGE)
      page_q <= wbyte & 8'h83;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ien_q <= page0_regs_pkg::IEN_RST;
    else if (wr && idx == page0_regs_pkg::IDX_IEN)
      ien_q <= wbyte;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      drive_q <= page0_regs_pkg::DRIVE_RST;
    else if (wr && idx == page0_regs_pkg::IDX_DRIVE)
      drive_q <= wbyte & 8'h80;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rx_off_q <= page0_regs_pkg::CMD_RST[page0_regs_pkg::RX_OFF_BIT];
    else if (wr_cmd)
      rx_off_q <= wbyte[page0_regs_pkg::RX_OFF_BIT];
  end

  // host write wins over a completion in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cmd_q <= page0_regs_pkg::CMD_RST[3:0];
    else if (wr_cmd)
      cmd_q <= cmd_known ? wbyte[3:0] : page0_regs_pkg::CMD_IDLE;
    else if (cmd_done)
      cmd_q <= page0_regs_pkg::CMD_IDLE;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      launch_q <= '0;
    else
    begin
      launch_q.start <= wr_cmd && cmd_known;
      launch_q.code <= wr_cmd ? wbyte[3:0] : launch_q.code;
    end
  end

  // soft power-down; bit stays one until the wake-up finishes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pwr_q <= page0_regs_pkg::PWR_AWAKE;
    else
    begin
      case (pwr_q)
        page0_regs_pkg::PWR_AWAKE:
          if (wr_cmd && wbyte[page0_regs_pkg::SLEEP_BIT] && !reinit_active)
            pwr_q <= page0_regs_pkg::PWR_ASLEEP;
        page0_regs_pkg::PWR_ASLEEP:
          if (wr_cmd && !wbyte[page0_regs_pkg::SLEEP_BIT])
            pwr_q <= page0_regs_pkg::PWR_WAKING;
        page0_regs_pkg::PWR_WAKING:
          if (wake_ready)
            pwr_q <= page0_regs_pkg::PWR_AWAKE;
        default: pwr_q <= page0_regs_pkg::PWR_AWAKE;
      endcase
    end
  end

  // sticky flags: a set in the clear cycle wins
  always_comb
  begin
    flags_d = flags_q;
    if (wr && idx == page0_regs_pkg::IDX_FLAGS)
      flags_d = flags_q & ~wbyte[6:0];
    flags_d = flags_d | {events.tx_done, events.rx_done, self_idle || unknown_idle,
      events.high_level, events.low_level, events.fault, events.countdown};
    if (wr && idx == page0_regs_pkg::IDX_FORCE)
      flags_d = flags_d | wbyte[6:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flags_q <= page0_regs_pkg::FLAGS_RST[6:0];
    else
      flags_q <= flags_d;
  end

  assign combined = |(flags_q & ien_q[6:0]);
  assign pin_level = combined ^ ien_q[page0_regs_pkg::INV_BIT];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      irq_q <= combined;
      // open drain only ever pulls low
      pin_out_q <= drive_q[page0_regs_pkg::DRIVE_BIT] ? pin_level : 1'b0;
      pin_oe_q <= drive_q[page0_regs_pkg::DRIVE_BIT] ? 1'b1 : !pin_level;
    end
  end

  // register address toward the register file
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_addr_q <= 6'h00;
    else if (page_q[page0_regs_pkg::PAGE_OVR_BIT])
      reg_addr_q <= {page_q[1:0], addr_latch[3:0]};
    else
      reg_addr_q <= addr_latch;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign reg_addr = reg_addr_q;
  assign launch = launch_q;
  assign receiver_analog_off = rx_off_q;
  assign soft_sleep_req = (pwr_q == page0_regs_pkg::PWR_ASLEEP);
  assign irq = irq_q;
  assign irq_pin_out = pin_out_q;
  assign irq_pin_oe = pin_oe_q;

  property p_page_override;
    @(posedge clk) disable iff (reset)
    page_q[7] && $stable(page_q) |=> reg_addr[5:4] == $past(page_q[1:0]);
  endproperty
  a_page_override: assert property (p_page_override) else $error("page bits not on address");

  property p_full_latch;
    @(posedge clk) disable iff (reset)
    !page_q[7] |=> reg_addr == $past(addr_latch);
  endproperty
  a_full_latch: assert property (p_full_latch) else $error("latch address not used");

  property p_rx_off;
    @(posedge clk) disable iff (reset)
    wr_cmd |=> receiver_analog_off == $past(wbyte[5]);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver off not following write");

  property p_sleep_refused;
    @(posedge clk) disable iff (reset)
    pwr_q == page0_regs_pkg::PWR_AWAKE && reinit_active |=> pwr_q == page0_regs_pkg::PWR_AWAKE;
  endproperty
  a_sleep_refused: assert property (p_sleep_refused) else $error("sleep entered during reinit");

  property p_wake_busy;
    @(posedge clk) disable iff (reset)
    pwr_q == page0_regs_pkg::PWR_WAKING && !wake_ready |=> pwr_q != page0_regs_pkg::PWR_AWAKE;
  endproperty
  a_wake_busy: assert property (p_wake_busy) else $error("woke before ready");

  property p_unknown_idle;
    @(posedge clk) disable iff (reset)
    unknown_idle |=> cmd_q == page0_regs_pkg::CMD_IDLE && flags_q[4] && !launch.start;
  endproperty
  a_unknown_idle: assert property (p_unknown_idle) else $error("unknown command not reverted");

  property p_pin_invert;
    @(posedge clk) disable iff (reset)
    drive_q[7] && $stable(flags_q) && $stable(ien_q) ##1 $stable(drive_q) && $stable(ien_q)
      |-> irq_pin_out == (irq ^ ien_q[7]);
  endproperty
  a_pin_invert: assert property (p_pin_invert) else $error("pin level wrong");

  property p_open_drain;
    @(posedge clk) disable iff (reset)
    !drive_q[7] |=> !irq_pin_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_combined;
    @(posedge clk) disable iff (reset)
    1'b1 |=> irq == |($past(flags_q) & $past(ien_q[6:0]));
  endproperty
  a_combined: assert property (p_combined) else $error("combined status wrong");

  property p_write_only;
    @(posedge clk) disable iff (reset)
    psel && !penable && !pwrite && idx == page0_regs_pkg::IDX_FORCE |=> prdata == 32'h0000_0000;
  endproperty
  a_write_only: assert property (p_write_only) else $error("write-only read nonzero");

  property p_page_hold;
    @(posedge clk) disable iff (reset)
    !(wr && idx == page0_regs_pkg::IDX_PAGE) |=> $stable(page_q);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed without host write");

  property p_ien_hold;
    @(posedge clk) disable iff (reset)
    !(wr && idx == page0_regs_pkg::IDX_IEN) |=> $stable(ien_q);
  endproperty
  a_ien_hold: assert property (p_ien_hold) else $error("enable changed without host write");

  property p_rd_upper;
    @(posedge clk) disable iff (reset)
    psel && !penable && !pwrite |=> prdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("unused read bits nonzero");

  property p_status_read;
    @(posedge clk) disable iff (reset)
    psel && !penable && !pwrite && idx == page0_regs_pkg::IDX_STATUS |=> prdata[3:0] == $past(cmd_q);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status not showing command");

  property p_launch;
    @(posedge clk) disable iff (reset)
    wr_cmd && cmd_known |=> launch.start && launch.code == $past(wbyte[3:0]);
  endproperty
  a_launch: assert property (p_launch) else $error("known command not launched");

  property p_cmd_done_idle;
    @(posedge clk) disable iff (reset)
    cmd_done && !wr_cmd |=> cmd_q == page0_regs_pkg::CMD_IDLE;
  endproperty
  a_cmd_done_idle: assert property (p_cmd_done_idle) else $error("finished command not idle");

  property p_self_idle;
    @(posedge clk) disable iff (reset)
    self_idle |=> flags_q[page0_regs_pkg::IDLE_FLAG_BIT];
  endproperty
  a_self_idle: assert property (p_self_idle) else $error("idle flag not set on finish");

  property p_sleep_enter;
    @(posedge clk) disable iff (reset)
    pwr_q == page0_regs_pkg::PWR_AWAKE && wr_cmd && wbyte[page0_regs_pkg::SLEEP_BIT] && !reinit_active
      |=> soft_sleep_req;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  property p_tx_flag;
    @(posedge clk) disable iff (reset)
    events.tx_done |=> flags_q[6];
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("event flag not set");

  property p_push_pull;
    @(posedge clk) disable iff (reset)
    drive_q[page0_regs_pkg::DRIVE_BIT] |=> irq_pin_oe;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

  property p_od_float;
    @(posedge clk) disable iff (reset)
    !drive_q[page0_regs_pkg::DRIVE_BIT] && pin_level |=> !irq_pin_oe;
  endproperty
  a_od_float: assert property (p_od_float) else $error("open drain pin not floating");
endmodule // page0_control_regs
`default_nettype wire

// [verification/host_apb_model.sv]
`default_nettype none
module host_apb_model (
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int stalls = 0;
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // production test registers are never addressed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr} <= {2'b10, w, a};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    if (n >= 64) stalls++;
    {psel, penable} <= 2'b00;
    // released lines show the inverse, not a stale value
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
endmodule // host_apb_model
`default_nettype wire

// [verification/nfc_page0_control_regs_tb_top.sv]
`default_nettype none
module nfc_page0_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] KNOWN = 16'h80FF;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_done = 1'b0;
  logic wake_ready = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, irq, rx_off, sleep_req, pin_out, pin_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] addr_latch = 6'h00;
  logic [5:0] reg_addr, ev;
  page0_regs_pkg::req_events_t events = '0;
  page0_regs_pkg::cmd_launch_t launch;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'h6B13FA5A;
  int m_flags, m_en, m_drv;
  page0_control_regs #(.ADDR_W(8), .SOFT_REINIT_CODE(4'hF), .KNOWN_CMD_MASK(KNOWN)) DUT (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_latch(addr_latch),
    .reg_addr(reg_addr), .events(events), .cmd_done(cmd_done), .wake_ready(wake_ready),
    .launch(launch), .receiver_analog_off(rx_off), .soft_sleep_req(sleep_req), .irq(irq),
    .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));
  host_apb_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    err_total += host.stalls;
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    host.xfer(w, a, d, rd, er);
    if (host.stalls != 0) report_and_stop();
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, {24'h000000, x});
  endtask
  task automatic chk_irq;
    logic c;
    c = (m_flags & m_en & 'h7F) != 0;
    chk("irq", irq, c);
    chk("pin", {pin_oe, pin_out}, m_drv ? {1'b1, c ^ m_en[7]} : {!(c ^ m_en[7]), 1'b0});
  endtask
  initial
  begin
    tick(5);
    reset <= 1'b0;
    rdc("page", 8'h00, 8'h00);
    rdc("cmd", 8'h04, 8'h20);
    rdc("ien", 8'h08, 8'h80);
    chk("pin_oe", pin_oe, 1'b0);
    rdc("force", 8'h4C, 8'h00);
    bus(1'b1, 8'h48, 8'hFF);
    rdc("status", 8'h48, 8'h00);
    bus(1'b0, 8'h80, 8'h00);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0000_0000);
    for (int pg = 0; pg < 4; pg++)
    begin
      addr_latch <= 6'($random(seed));
      bus(1'b1, 8'h00, 8'(8'h80 | pg));
      tick(2);
      chk("ovr_addr", reg_addr, {pg[1:0], addr_latch[3:0]});
      rdc("page", 8'h00, 8'(8'h80 | pg));
      bus(1'b1, 8'h00, 8'(pg));
      tick(2);
      chk("latch_addr", reg_addr, addr_latch);
    end
    for (int k = 0; k < 4; k++)
    begin
      m_en = ($random(seed) & 'h7F) | ((k & 1) << 7);
      m_drv = k >> 1;
      ev = 6'($random(seed));
      bus(1'b1, 8'h08, 8'(m_en));
      bus(1'b1, 8'h44, 8'(m_drv << 7));
      events <= ev;
      tick(1);
      events <= '0;
      tick(3);
      m_flags = {ev[5:4], 1'b0, ev[3:0]};
      chk_irq();
      rdc("flags", 8'h40, 8'(m_flags));
      rdc("status", 8'h48, 8'(((m_flags & m_en & 'h7F) != 0) << 4));
      bus(1'b1, 8'h40, 8'h7F);
      m_flags = 0;
      tick(2);
      chk_irq();
    end
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b1, 8'h04, 8'({c[0], 1'b0, c[3:0]}));
      #1 chk("start", launch.start, KNOWN[c]);
      chk("code", launch.code, 32'(c[3:0]));
      tick(2);
      chk("rx_off", rx_off, c[0]);
      if (KNOWN[c] && c != 0)
      begin
        rdc("running", 8'h04, 8'({c[0], 1'b0, c[3:0]}));
        cmd_done <= 1'b1;
        tick(1);
        cmd_done <= 1'b0;
      end
      tick(2);
      rdc("cmd", 8'h04, 8'({c[0], 5'h00}));
      rdc("idle", 8'h40, 8'((c != 0) << 4));
      bus(1'b1, 8'h40, 8'h7F);
    end
    bus(1'b1, 8'h04, 8'h30);
    tick(2);
    chk("sleep", sleep_req, 1'b1);
    rdc("cmd", 8'h04, 8'h30);
    bus(1'b1, 8'h04, 8'h20);
    tick(2);
    chk("sleep", sleep_req, 1'b0);
    rdc("waking", 8'h04, 8'h30);
    rdc("status", 8'h48, 8'h20);
    wake_ready <= 1'b1;
    tick(1);
    wake_ready <= 1'b0;
    tick(2);
    rdc("awake", 8'h04, 8'h20);
    bus(1'b1, 8'h04, 8'h2F);
    bus(1'b1, 8'h04, 8'h3F);
    tick(2);
    chk("sleep", sleep_req, 1'b0);
    rdc("cmd", 8'h04, 8'h2F);
    bus(1'b1, 8'h4C, 8'h41);
    rdc("forced", 8'h40, 8'h41);
    rdc("force", 8'h4C, 8'h00);
    report_and_stop();
  end
endmodule // nfc_page0_control_regs_tb_top
`default_nettype wire
